// >>> tgc_pkg.sv
/*
 * Shared constants for the test-source and pin configuration bank:
 * register indices, reset values, field layouts and legal level maps.
 * Assumes one 8-bit register per aligned 32-bit APB word.
 */
package tgc_pkg;

   // ----------------------------------------------------------------
   // Register geometry
   // ----------------------------------------------------------------
   localparam int          REG_W        = 8;     // Register width
   localparam int          IDX_W        = 8;     // Register index width
   localparam int          ADDR_W       = 12;    // APB address width
   localparam int          LEVEL_W      = 5;     // Level code width

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0]  IDX_POS_CTRL = 8'h10; // Positive source ctrl
   localparam logic [7:0]  IDX_NEG_CTRL = 8'h11; // Negative source ctrl
   localparam logic [7:0]  IDX_LINK     = 8'h12; // Pin analog link
   localparam logic [7:0]  IDX_DIR      = 8'h13; // Pin direction
   localparam logic [7:0]  IDX_VALUE    = 8'h14; // Pin value

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_CTRL     = 8'h00; // Both source ctrls
   localparam logic [7:0]  RST_LINK     = 8'h00; // All pins unlinked
   localparam logic [7:0]  RST_DIR      = 8'h00; // All pins outputs
   localparam logic [7:0]  RST_VALUE    = 8'h00; // All pin data low

   // ----------------------------------------------------------------
   // Source control field layout
   // ----------------------------------------------------------------
   localparam int          CTRL_LINK_BIT = 7;    // Output to pin link
   localparam logic [7:0]  CTRL_WMASK   = 8'h9f; // Writable bits
   localparam logic [7:0]  CTRL_RSVD    = 8'h60; // Read-as-zero bits

   // ----------------------------------------------------------------
   // Legal level codes, one bit per code
   // ----------------------------------------------------------------
   localparam logic [31:0] POS_LEGAL    = 32'h10ce_037f;
   localparam logic [31:0] NEG_LEGAL    = 32'h01ee_03ff;

   // Checks a level code against a legal map
   function automatic logic level_ok(input logic [31:0]  map,
                                     input logic [4:0]   code);
      level_ok = map[code];
   endfunction

endpackage : tgc_pkg

// >>> tgc_reg_if.sv
/*
 * Internal register access carrier between the APB slave and the bank.
 * Assumes the bank answers reads combinationally from its index.
 */
`timescale 1ns/100ps

interface tgc_reg_if;
   logic       wr_en;    // One-cycle write strobe
   logic [7:0] wr_idx;   // Write register index
   logic [7:0] wr_data;  // Write data
   logic [7:0] rd_idx;   // Read register index
   logic [7:0] rd_data;  // Read data
   logic       hit;      // Read index is mapped

   // Bus side issues requests
   modport bus  (output wr_en, wr_idx, wr_data, rd_idx,
                 input  rd_data, hit);
   // Bank side serves them
   modport bank (input  wr_en, wr_idx, wr_data, rd_idx,
                 output rd_data, hit);
endinterface : tgc_reg_if

// >>> tgc_apb_slave.sv
/*
 * APB slave front end. Every transfer completes in two cycles: setup,
 * then one access cycle with pready high. Unmapped words answer with
 * pslverr and read data zero; their writes are dropped.
 * Assumes a well-behaved APB master on pclk.
 */
`timescale 1ns/100ps

module tgc_apb_slave
   import tgc_pkg::*;
(
   input  wire logic              pclk,     // Bus clock
   input  wire logic              presetn,  // Async reset, active low
   input  wire logic              psel,     // Slave select
   input  wire logic              penable,  // Access phase
   input  wire logic              pwrite,   // Write direction
   input  wire logic [ADDR_W-1:0] paddr,    // Byte address
   input  wire logic [31:0]       pwdata,   // Write data
   output logic                   pready,   // Transfer done
   output logic [31:0]            prdata,   // Read data
   output logic                   pslverr,  // Unmapped access
   tgc_reg_if.bus                 rif       // Register access
);
   import tgc_pkg::*;

   // ----------------------------------------------------------------
   // Phase tracking
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TGC_IDLE   = 2'b01,   // Waiting for a setup cycle
      TGC_ACCESS = 2'b10    // Answering in the access cycle
   } tgc_phase_e;

   tgc_phase_e  state;        // Current phase
   tgc_phase_e  next_state;   // Next phase
   logic        next_pready;  // Next ready
   logic [31:0] next_prdata;  // Next read data
   logic        next_pslverr; // Next error
   logic        aligned;      // Word-aligned address

   // Word index taken from the byte address
   assign rif.rd_idx  = paddr[9:2];
   assign rif.wr_idx  = paddr[9:2];
   assign rif.wr_data = pwdata[7:0];
   assign aligned     = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);

   // Write lands at the edge where the master samples pready
   assign rif.wr_en   = (state == TGC_ACCESS) && psel && penable
                        && pwrite && !pslverr;

   // Next phase, ready, data and error
   always_comb begin
      next_state   = state;
      next_pready  = 1'b0;
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      unique case (state)
         TGC_IDLE: begin
            // Setup cycle seen: prepare the answer
            if (psel && !penable) begin
               next_state   = TGC_ACCESS;
               next_pready  = 1'b1;
               next_pslverr = !(aligned && rif.hit);
               if (!pwrite && aligned && rif.hit) begin
                  next_prdata = {24'h00_0000, rif.rd_data};
               end
            end
         end
         TGC_ACCESS: begin
            // Single access cycle, then back to idle
            next_state = TGC_IDLE;
         end
         default: begin
            // Illegal code recovers to idle
            next_state = TGC_IDLE;
         end
      endcase
   end

   // Register the phase and the answer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state   <= TGC_IDLE;
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         state   <= next_state;
         pready  <= next_pready;
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

endmodule // tgc_apb_slave

// >>> tgc_pin_drive.sv
/*
 * General-purpose pin drivers: drive level and enable per pin from the
 * stored direction and value, and a registered sample of each pin.
 * Assumes pin inputs are synchronous to pclk.
 */
`timescale 1ns/100ps

module tgc_pin_drive
   import tgc_pkg::*;
#(
   parameter int N = 8                     // Number of pins
) (
   input  wire logic         pclk,         // Clock
   input  wire logic         presetn,      // Async reset, active low
   input  wire logic [N-1:0] dir,          // 1 = input, 0 = output
   input  wire logic [N-1:0] value,        // Stored pin data
   input  wire logic [N-1:0] pin_in,       // Pin level seen
   output logic      [N-1:0] pin_out,      // Pin drive level
   output logic      [N-1:0] pin_oe,       // Pin drive enable
   output logic      [N-1:0] pin_sample    // Registered pin level
);
   import tgc_pkg::*;

   // ----------------------------------------------------------------
   // Drive and sample
   // ----------------------------------------------------------------
   logic [N-1:0] next_out;   // Next drive level
   logic [N-1:0] next_oe;    // Next enable
   logic [N-1:0] next_samp;  // Next sample

   // Direction clear drives the stored value onto the pin
   always_comb begin
      next_oe   = ~dir;
      next_out  = value & ~dir;
      next_samp = pin_in;
   end

   // Register drive and sample
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out    <= '0;
         pin_oe     <= '0;
         pin_sample <= '0;
      end else begin
         pin_out    <= next_out;
         pin_oe     <= next_oe;
         pin_sample <= next_samp;
      end
   end

endmodule // tgc_pin_drive

// >>> tgc_config_bank.sv
/*
 * Configuration bank for the two test signal sources and the eight
 * general-purpose pins, reached over APB.
 * Assumes a single pclk domain and an APB master that honours pready.
 */
// Behaviour
// - positive link bit ties source to AIN6
// - bits 6:5 of source controls read zero
// - positive level code selects source voltage
// - negative level code selects source voltage
// - negative link bit ties source to AIN7
// - negative control at 11h, resets 00h
// - link bit n ties pin n to input
// - pin link register at 12h, resets 00h
// - direction bit: 0 output, 1 input
// - direction register at 13h, resets 00h
// - pin data register at 14h, resets 00h
// - positive control at 10h, resets 00h
// - output pins read stored, inputs store only
`timescale 1ns/100ps

module tgc_config_bank
   import tgc_pkg::*;
#(
   parameter int PINS = 8                          // Pin count
) (
   input  wire logic               pclk,           // Clock, 100 MHz
   input  wire logic               presetn,        // Async reset, low
   input  wire logic               psel,           // APB select
   input  wire logic               penable,        // APB enable
   input  wire logic               pwrite,         // APB direction
   input  wire logic [ADDR_W-1:0]  paddr,          // APB address
   input  wire logic [31:0]        pwdata,         // APB write data
   output logic                    pready,         // APB ready
   output logic [31:0]             prdata,         // APB read data
   output logic                    pslverr,        // APB error
   output logic                    positive_source_pin_link, // To AIN6
   output logic                    negative_source_pin_link, // To AIN7
   output logic [LEVEL_W-1:0]      positive_source_level,    // Level
   output logic [LEVEL_W-1:0]      negative_source_level,    // Level
   output logic                    positive_level_legal,     // Listed
   output logic                    negative_level_legal,     // Listed
   output logic [PINS-1:0]         pin_link_bits,  // Pin to analog
   input  wire logic [PINS-1:0]    pin_in,         // Pin levels
   output logic [PINS-1:0]         pin_out,        // Pin drive levels
   output logic [PINS-1:0]         pin_oe          // Pin drive enables
);
   import tgc_pkg::*;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [REG_W-1:0] pos_ctrl;        // Positive source control
   logic [REG_W-1:0] neg_ctrl;        // Negative source control
   logic [PINS-1:0]  link;            // Pin analog link
   logic [PINS-1:0]  dir;             // Pin direction
   logic [PINS-1:0]  pin_value_bits;  // Stored pin data
   logic [REG_W-1:0] next_pos_ctrl;   // Next positive control
   logic [REG_W-1:0] next_neg_ctrl;   // Next negative control
   logic [PINS-1:0]  next_link;       // Next pin link
   logic [PINS-1:0]  next_dir;        // Next direction
   logic [PINS-1:0]  next_value;      // Next pin data
   logic [PINS-1:0]  pin_sample;      // Registered pin levels
   logic [PINS-1:0]  value_view;      // Pin data as read back
   logic               next_pos_link;   // Next positive source link
   logic               next_neg_link;   // Next negative source link
   logic [LEVEL_W-1:0] next_pos_level;  // Next positive level code
   logic [LEVEL_W-1:0] next_neg_level;  // Next negative level code
   logic               next_pos_legal;  // Next positive listed flag
   logic               next_neg_legal;  // Next negative listed flag
   logic [PINS-1:0]    next_pin_link;   // Next pin analog link

   tgc_reg_if rif ();                 // Bus to bank carrier

   // ----------------------------------------------------------------
   // Bus front end
   // ----------------------------------------------------------------
   tgc_apb_slave u_apb (
      .pclk    (pclk),
      .presetn (presetn),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .pready  (pready),
      .prdata  (prdata),
      .pslverr (pslverr),
      .rif     (rif)
   );

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // Next register values from the write strobe
   always_comb begin
      next_pos_ctrl = pos_ctrl;
      next_neg_ctrl = neg_ctrl;
      next_link     = link;
      next_dir      = dir;
      next_value    = pin_value_bits;
      if (rif.wr_en) begin
         unique case (rif.wr_idx)
            IDX_POS_CTRL: begin
               next_pos_ctrl = rif.wr_data & CTRL_WMASK;
            end
            IDX_NEG_CTRL: begin
               next_neg_ctrl = rif.wr_data & CTRL_WMASK;
            end
            IDX_LINK: begin
               next_link = rif.wr_data[PINS-1:0];
            end
            IDX_DIR: begin
               next_dir = rif.wr_data[PINS-1:0];
            end
            IDX_VALUE: begin
               next_value = rif.wr_data[PINS-1:0];
            end
            default: begin
               // Unmapped index, nothing stored
            end
         endcase
      end
   end

   // Register state, all zero after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_ctrl       <= RST_CTRL;
         neg_ctrl       <= RST_CTRL;
         link           <= RST_LINK;
         dir            <= RST_DIR;
         pin_value_bits <= RST_VALUE;
      end else begin
         pos_ctrl       <= next_pos_ctrl;
         neg_ctrl       <= next_neg_ctrl;
         link           <= next_link;
         dir            <= next_dir;
         pin_value_bits <= next_value;
      end
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   // output pins read stored data
   assign value_view = (pin_value_bits & ~dir) | (pin_sample & dir);

   // Read mux by index
   always_comb begin
      rif.rd_data = 8'h00;
      rif.hit     = 1'b1;
      unique case (rif.rd_idx)
         IDX_POS_CTRL: rif.rd_data = pos_ctrl;
         IDX_NEG_CTRL: rif.rd_data = neg_ctrl;
         IDX_LINK:     rif.rd_data = link;
         IDX_DIR:      rif.rd_data = dir;
         IDX_VALUE:    rif.rd_data = value_view;
         default: begin
            // Unmapped word answers with an error
            rif.hit = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   // direction steers drive enable
   tgc_pin_drive #(.N(PINS)) u_pins (
      .pclk       (pclk),
      .presetn    (presetn),
      .dir        (dir),
      .value      (pin_value_bits),
      .pin_in     (pin_in),
      .pin_out    (pin_out),
      .pin_oe     (pin_oe),
      .pin_sample (pin_sample)
   );

   // ----------------------------------------------------------------
   // Analog control outputs
   // ----------------------------------------------------------------
   // Next analog switch and level controls from the stored registers
   always_comb begin
      next_pos_link  = pos_ctrl[CTRL_LINK_BIT];
      next_neg_link  = neg_ctrl[CTRL_LINK_BIT];
      next_pos_level = pos_ctrl[LEVEL_W-1:0];
      next_neg_level = neg_ctrl[LEVEL_W-1:0];
      next_pos_legal = level_ok(POS_LEGAL, pos_ctrl[LEVEL_W-1:0]);
      next_neg_legal = level_ok(NEG_LEGAL, neg_ctrl[LEVEL_W-1:0]);
      next_pin_link  = link;
   end

   // Registered copies of the analog switch and level controls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         positive_source_pin_link <= 1'b0;
         negative_source_pin_link <= 1'b0;
         positive_source_level    <= '0;
         negative_source_level    <= '0;
         positive_level_legal     <= 1'b1;
         negative_level_legal     <= 1'b1;
         pin_link_bits            <= '0;
      end else begin
         positive_source_pin_link <= next_pos_link;
         negative_source_pin_link <= next_neg_link;
         positive_source_level    <= next_pos_level;
         negative_source_level    <= next_neg_level;
         positive_level_legal     <= next_pos_legal;
         negative_level_legal     <= next_neg_legal;
         pin_link_bits            <= next_pin_link;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   wire wr_pos = rif.wr_en && (rif.wr_idx == IDX_POS_CTRL);
   wire wr_neg = rif.wr_en && (rif.wr_idx == IDX_NEG_CTRL);

   pos_link_follow_a: assert property (
      wr_pos |=> ##1 positive_source_pin_link == $past(pwdata[7], 2))
      else $error("positive link does not follow write");

   rsvd_zero_a: assert property (
      ((pos_ctrl | neg_ctrl) & CTRL_RSVD) == 8'h00)
      else $error("reserved source bits not zero");

   pos_level_a: assert property (
      wr_pos |=> ##1 positive_source_level == $past(pwdata[4:0], 2))
      else $error("positive level mismatch");

   neg_level_a: assert property (
      wr_neg |=> ##1 negative_source_level == $past(pwdata[4:0], 2))
      else $error("negative level mismatch");

   neg_link_follow_a: assert property (
      wr_neg |=> ##1 negative_source_pin_link == $past(pwdata[7], 2))
      else $error("negative link does not follow write");

   neg_decode_a: assert property (
      wr_neg |=> neg_ctrl == ($past(pwdata[7:0]) & CTRL_WMASK))
      else $error("negative control not stored");

   pos_decode_a: assert property (
      wr_pos |=> pos_ctrl == ($past(pwdata[7:0]) & CTRL_WMASK))
      else $error("positive control not stored");

   dir_decode_a: assert property (
      (rif.wr_en && rif.wr_idx == IDX_DIR)
      |=> dir == $past(pwdata[7:0]))
      else $error("pin direction not stored");

   link_decode_a: assert property (
      (rif.wr_en && rif.wr_idx == IDX_LINK)
      |=> ##1 pin_link_bits == $past(pwdata[7:0], 2))
      else $error("pin link not stored");

   dir_drive_a: assert property (
      $stable(dir) [*2] |-> pin_oe == ~dir)
      else $error("drive enable does not match direction");

   value_store_a: assert property (
      (rif.wr_en && rif.wr_idx == IDX_VALUE)
      |=> pin_value_bits == $past(pwdata[7:0]))
      else $error("pin data not stored");

   read_view_a: assert property (
      (psel && !penable && !pwrite && rif.rd_idx == IDX_VALUE
       && paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0)
      |=> pready && prdata[7:0] == $past(value_view))
      else $error("pin data read mismatch");

   unmapped_err_a: assert property (
      (psel && !penable && !rif.hit) |=> pready && pslverr)
      else $error("unmapped access not refused");

   one_wait_a: assert property (
      (psel && !penable && !pready) |=> pready ##1 !pready)
      else $error("access phase not one cycle");

   pos_write_c: cover property (wr_pos ##2 positive_source_pin_link);
   neg_write_c: cover property (wr_neg ##2 !negative_level_legal);
   in_read_c:   cover property (dir != 8'h00 ##1 pready && !pwrite);
   err_c:       cover property (pready && pslverr);

endmodule // tgc_config_bank

// >>> tgc_host_model.sv
/*
 * Host-side APB master model for the configuration bank.
 * Assumes one pclk domain and a slave that raises pready.
 */
`timescale 1ns/100ps

module tgc_host_model
   import tgc_pkg::*;
(
   input  wire logic         pclk,     // Bus clock
   input  wire logic         pready,   // Slave done
   input  wire logic [31:0]  prdata,   // Read data
   input  wire logic         pslverr,  // Slave error
   output logic              psel,     // Select
   output logic              penable,  // Access phase
   output logic              pwrite,   // Direction
   output logic [ADDR_W-1:0] paddr,    // Byte address
   output logic [31:0]       pwdata    // Write data
);
   // ----------------------------------------------------------------
   // Idle bus at time zero
   // ----------------------------------------------------------------
   initial begin
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= '0;
      pwdata <= '0;
   end

   // One transfer, held until pready; ok stays low on a hang
   task automatic xfer(input logic w, input logic [7:0] idx,
                       input logic [7:0] d, output logic [31:0] rd,
                       output logic err, output logic ok);
      int n;
      ok = 1'b0;
      rd = '0;
      err = 1'b0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16 && !ok; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            ok = 1'b1;
            rd = prdata;
            err = pslverr;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // tgc_host_model

// >>> tb.sv
/*
 * Self-checking bench for the configuration bank.
 * Assumes the host model in tgc_host_model.sv.
 */
`timescale 1ns/100ps

module tb;
   import tgc_pkg::*;
   logic              pclk = 1'b0;     // Clock
   logic              presetn = 1'b0;  // Reset, active low
   logic              psel, penable, pwrite, pready, pslverr;
   logic [ADDR_W-1:0] paddr;           // Byte address
   logic [31:0]       pwdata, prdata;  // Bus data
   logic              pl, nl, plg, nlg; // Links and legal flags
   logic [4:0]        plv, nlv;        // Level codes
   logic [7:0]        lnk, pin_out, pin_oe, pin_in;
   logic [7:0]        ext_lvl = 8'h00; // Far-side pin level
   int                err_total = 0;   // Mismatches
   int                checks = 0;      // Comparisons

   always #5 pclk = ~pclk;
   // Pin wire: driven level where enabled, else outside level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);

   tgc_host_model host (.pclk(pclk), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

   tgc_config_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .positive_source_pin_link(pl),
      .negative_source_pin_link(nl), .positive_source_level(plv),
      .negative_source_level(nlv), .positive_level_legal(plg),
      .negative_level_legal(nlg), .pin_link_bits(lnk),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

   task automatic give_verdict();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One access, checking completion and the error answer
   task automatic acc(input logic w, input logic [7:0] idx,
                      input logic [7:0] d, input logic ee,
                      output logic [31:0] rd);
      logic e, ok;
      host.xfer(w, idx, d, rd, e, ok);
      if (ok !== 1'b1) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, ok, 1'b1);
         give_verdict();
      end else begin
         chk({31'h0, e}, {31'h0, ee});
      end
   endtask

   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] rd;
      acc(1'b0, idx, 8'h00, 1'b0, rd);
      chk(rd, {24'h0, exp});
   endtask

   // Outputs follow one edge after the register
   task automatic settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask

   task automatic t_reset();
      rdchk(IDX_POS_CTRL, RST_CTRL);
      rdchk(IDX_NEG_CTRL, RST_CTRL);
      rdchk(IDX_LINK, RST_LINK);
      rdchk(IDX_DIR, RST_DIR);
      rdchk(IDX_VALUE, RST_VALUE);
      chk({24'h0, pin_oe}, 32'hff);
      $display("test reset done");
   endtask

   task automatic t_ctrl();
      logic [31:0] rd;
      acc(1'b1, IDX_POS_CTRL, 8'hff, 1'b0, rd);
      acc(1'b1, IDX_NEG_CTRL, 8'hff, 1'b0, rd);
      rdchk(IDX_POS_CTRL, 8'h9f);
      rdchk(IDX_NEG_CTRL, 8'h9f);
      settle();
      chk({30'h0, pl, nl}, 32'h3);
      chk({22'h0, plv, nlv}, 32'h3ff);
      acc(1'b1, IDX_POS_CTRL, 8'h00, 1'b0, rd);
      acc(1'b1, IDX_NEG_CTRL, 8'h00, 1'b0, rd);
      settle();
      chk({30'h0, pl, nl}, 32'h0);
      $display("test ctrl done");
   endtask

   task automatic t_levels();
      logic [7:0]  pc[4] = '{8'h09, 8'h1c, 8'h07, 8'h1f};
      logic [7:0]  nc[4] = '{8'h07, 8'h15, 8'h18, 8'h1c};
      logic [1:0]  lg[4] = '{2'b11, 2'b11, 2'b01, 2'b00};
      logic [31:0] rd;
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, IDX_POS_CTRL, pc[i], 1'b0, rd);
         acc(1'b1, IDX_NEG_CTRL, nc[i], 1'b0, rd);
         settle();
         chk({22'h0, plv, nlv}, {22'h0, pc[i][4:0], nc[i][4:0]});
         chk({30'h0, plg, nlg}, {30'h0, lg[i]});
      end
      $display("test levels done");
   endtask

   task automatic t_pins();
      logic [31:0] rd;
      @(posedge pclk);
      ext_lvl <= 8'h0a;
      acc(1'b1, IDX_LINK, 8'ha5, 1'b0, rd);
      acc(1'b1, IDX_DIR, 8'h0f, 1'b0, rd);
      acc(1'b1, IDX_VALUE, 8'h3c, 1'b0, rd);
      settle();
      chk({24'h0, lnk}, 32'ha5);
      chk({16'h0, pin_oe, pin_out}, 32'hf030);
      rdchk(IDX_VALUE, 8'h3a);
      rdchk(IDX_DIR, 8'h0f);
      acc(1'b1, IDX_DIR, 8'h00, 1'b0, rd);
      settle();
      chk({16'h0, pin_oe, pin_out}, 32'hff3c);
      rdchk(IDX_VALUE, 8'h3c);
      $display("test pins done");
   endtask

   task automatic t_err();
      logic [31:0] rd;
      acc(1'b1, 8'h15, 8'hff, 1'b1, rd);
      acc(1'b0, 8'h0f, 8'h00, 1'b1, rd);
      chk(rd, 32'h0);
      rdchk(IDX_LINK, 8'ha5);
      $display("test unmapped done");
   endtask

   // Main sequence
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_ctrl();
      t_levels();
      t_pins();
      t_err();
      give_verdict();
   end
endmodule // tb
